//--- hdl/probe_route_pkg.sv
package probe_route_pkg;
   // configuration byte addresses
   localparam logic [7:0] ADDR_BUS_ENABLE = 8'h17;
   localparam logic [7:0] ADDR_MODE = 8'hF0;
   localparam logic [7:0] ADDR_MAP_COUNT = 8'hF3;
   localparam logic [7:0] ADDR_PAD_MAP = 8'hF4;
   localparam logic [7:0] ADDR_DAC_ONE = 8'hF8;
   localparam logic [7:0] ADDR_DAC_TWO = 8'hF9;
   // field layout of a pad map byte
   localparam int PAD_SEL_LSB = 4;
   localparam int BIT_SEL_LSB = 0;
   localparam logic [3:0] BIT_SEL_CLOCK = 4'h8;
   localparam logic [3:0] PAD_LAST = 4'h3;
   // probe bus mode codes
   localparam logic [7:0] MODE_ANALOG = 8'h01;
   localparam logic [7:0] MODE_DIGITAL = 8'h02;
   // reset values and pad and map counts
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_MAP = 32'h0000_0000;
   localparam int NUM_PADS = 4;
   localparam int NUM_MAPS = 4;

   // pad order: 0 power request, 1 aux two, 2 download request, 3 aux one
   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_DIGITAL = 2'b01,
      CMD_ANALOG = 2'b10
   } probe_cmd_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
   } cfg_wr_t;

   typedef struct packed {
      logic [7:0] bus_enable;
      logic [7:0] probe_bus_mode;
      logic [7:0] pad_map_count;
      logic [31:0] pad_probe_map;
      logic [7:0] dac_one_source;
      logic [7:0] dac_two_source;
   } cfg_regs_t;

   typedef struct packed {
      logic [3:0] pad_val;
      logic [3:0] pad_oe;
      logic analog_on;
      logic [7:0] dac_one_word;
      logic [7:0] dac_two_word;
      logic [7:0] rdata;
   } route_out_t;
endpackage : probe_route_pkg

//--- hdl/debug_testbus_routing.sv
// Operation
// - no probe routing without bus enable byte
// - two analog or four digital probes max
// - analog probes come from two DAC words
// - digital and analog commands configure separately
// - map upper nibble picks the pad
// - lower nibble picks bus bit, eight clock
// - four byte read/write pad map area
// - first DAC drives the power request pad
// - second DAC drives auxiliary pad two
// - only pad_map_count map entries apply
// - mode one analog, mode two digital
`timescale 1ns/1ps
module debug_testbus_routing (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // configuration port
   input wire logic [7:0] cfg_addr_i,
   input wire logic [7:0] cfg_wdata_i,
   input wire logic cfg_we_i,
   input wire logic [1:0] probe_cmd_i,
   output logic [7:0] cfg_rdata_o,
   // internal sources
   input wire logic [7:0] probe_bus_i,
   input wire logic clk13_i,
   input wire logic [3:0] func_val_i,
   input wire logic [3:0] func_oe_i,
   input wire logic [7:0] dsp_word_one_i,
   input wire logic [7:0] dsp_word_two_i,
   // pads and DAC
   output logic [3:0] pad_val_o,
   output logic [3:0] pad_oe_o,
   output logic analog_on_o,
   output logic [7:0] dac_one_word_o,
   output logic [7:0] dac_two_word_o
);

   typedef struct packed {
      probe_route_pkg::cfg_regs_t cfg;
      probe_route_pkg::route_out_t out;
   } state_t;

   // reset image of the whole state; outputs stay low until the first edge
   localparam state_t STATE_RST = '{
      cfg: '{
         bus_enable: probe_route_pkg::RST_BYTE,
         probe_bus_mode: probe_route_pkg::RST_BYTE,
         pad_map_count: probe_route_pkg::RST_BYTE,
         pad_probe_map: probe_route_pkg::RST_MAP,
         dac_one_source: probe_route_pkg::RST_BYTE,
         dac_two_source: probe_route_pkg::RST_BYTE
      },
      out: '0
   };

   state_t s_q;
   state_t s_d;
   probe_route_pkg::cfg_wr_t wr;

   function automatic logic [7:0] map_byte(input logic [31:0] m, input int i);
      map_byte = m[i*8 +: 8];
   endfunction : map_byte

   // byte address of pad map entry i; shared by the write and the read decode
   function automatic logic map_hit(input logic [7:0] a, input int i);
      map_hit = (a == probe_route_pkg::ADDR_PAD_MAP + 8'(i));
   endfunction : map_hit

   assign wr = '{addr: cfg_addr_i, wdata: cfg_wdata_i, we: cfg_we_i};

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic en;
      logic dig;
      logic ana;
      logic [7:0] mb;
      logic [3:0] pad;
      logic [3:0] bsel;
      int j;
      en = 1'b0;
      dig = 1'b0;
      ana = 1'b0;
      mb = 8'h00;
      pad = 4'h0;
      bsel = 4'h0;
      j = 0;
      s_d = s_q;
      if (wr.we) begin
         unique case (wr.addr)
            probe_route_pkg::ADDR_BUS_ENABLE: s_d.cfg.bus_enable = wr.wdata;
            probe_route_pkg::ADDR_MODE: s_d.cfg.probe_bus_mode = wr.wdata;
            probe_route_pkg::ADDR_MAP_COUNT: s_d.cfg.pad_map_count = wr.wdata;
            probe_route_pkg::ADDR_DAC_ONE: s_d.cfg.dac_one_source = wr.wdata;
            probe_route_pkg::ADDR_DAC_TWO: s_d.cfg.dac_two_source = wr.wdata;
            default: begin
               // four map bytes at consecutive addresses
               for (j = 0; j < probe_route_pkg::NUM_MAPS; j++) begin
                  if (map_hit(wr.addr, j)) begin
                     s_d.cfg.pad_probe_map[j*8 +: 8] = wr.wdata;
                  end
               end
            end
         endcase
      end
      // a command overrides the stored mode for its own probe type
      if (probe_cmd_i == probe_route_pkg::CMD_DIGITAL) begin
         s_d.cfg.probe_bus_mode = probe_route_pkg::MODE_DIGITAL;
      end else if (probe_cmd_i == probe_route_pkg::CMD_ANALOG) begin
         s_d.cfg.probe_bus_mode = probe_route_pkg::MODE_ANALOG;
      end
      // routing uses the settled configuration, one cycle behind a write
      en = s_q.cfg.bus_enable[0];
      dig = en && (s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_DIGITAL);
      ana = en && (s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_ANALOG);
      s_d.out.pad_val = func_val_i;
      s_d.out.pad_oe = func_oe_i;
      if (dig) begin
         for (j = 0; j < probe_route_pkg::NUM_MAPS; j++) begin
            mb = map_byte(s_q.cfg.pad_probe_map, j);
            pad = mb[probe_route_pkg::PAD_SEL_LSB +: 4];
            bsel = mb[probe_route_pkg::BIT_SEL_LSB +: 4];
            // reserved pad codes and bit codes above eight are ignored
            if (8'(j) < s_q.cfg.pad_map_count && pad <= probe_route_pkg::PAD_LAST
                && bsel <= probe_route_pkg::BIT_SEL_CLOCK) begin
               s_d.out.pad_oe[pad[1:0]] = 1'b1;
               s_d.out.pad_val[pad[1:0]] = (bsel == probe_route_pkg::BIT_SEL_CLOCK) ?
                  clk13_i : probe_bus_i[bsel[2:0]];
            end
         end
      end
      s_d.out.analog_on = ana;
      // pad 0 and pad 1 are handed to the two DACs; digital drive released
      if (ana) begin
         s_d.out.pad_oe[0] = 1'b0;
         s_d.out.pad_oe[1] = 1'b0;
         s_d.out.pad_val[0] = 1'b0;
         s_d.out.pad_val[1] = 1'b0;
      end
      // source byte picks which data word feeds each DAC
      s_d.out.dac_one_word = !ana ? 8'h00 :
         (s_q.cfg.dac_one_source[0] ? dsp_word_two_i : dsp_word_one_i);
      s_d.out.dac_two_word = !ana ? 8'h00 :
         (s_q.cfg.dac_two_source[0] ? dsp_word_two_i : dsp_word_one_i);
      unique case (cfg_addr_i)
         probe_route_pkg::ADDR_BUS_ENABLE: s_d.out.rdata = s_q.cfg.bus_enable;
         probe_route_pkg::ADDR_MODE: s_d.out.rdata = s_q.cfg.probe_bus_mode;
         probe_route_pkg::ADDR_MAP_COUNT: s_d.out.rdata = s_q.cfg.pad_map_count;
         probe_route_pkg::ADDR_DAC_ONE: s_d.out.rdata = s_q.cfg.dac_one_source;
         probe_route_pkg::ADDR_DAC_TWO: s_d.out.rdata = s_q.cfg.dac_two_source;
         default: begin
            s_d.out.rdata = 8'h00;
            for (j = 0; j < probe_route_pkg::NUM_MAPS; j++) begin
               if (map_hit(cfg_addr_i, j)) begin
                  s_d.out.rdata = map_byte(s_q.cfg.pad_probe_map, j);
               end
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q <= STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg_rdata_o = s_q.out.rdata;
   assign pad_val_o = s_q.out.pad_val;
   assign pad_oe_o = s_q.out.pad_oe;
   assign analog_on_o = s_q.out.analog_on;
   assign dac_one_word_o = s_q.out.dac_one_word;
   assign dac_two_word_o = s_q.out.dac_two_word;

   ////////////////////////////////////////////////////////////////////////////
   chk_disabled_passthru: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.cfg.bus_enable[0] ##1 1'b1 |-> pad_oe_o == $past(func_oe_i))
      else $error("pads altered while probe bus disabled");
   chk_dac_off_digital: assert property (@(posedge clk_i) disable iff (rst_i)
      !analog_on_o |-> dac_one_word_o == 8'h00 && dac_two_word_o == 8'h00)
      else $error("dac active outside analog mode");
   chk_cmd_digital: assert property (@(posedge clk_i) disable iff (rst_i)
      probe_cmd_i == probe_route_pkg::CMD_DIGITAL |=>
         s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_DIGITAL)
      else $error("digital command not applied");
   chk_cmd_analog: assert property (@(posedge clk_i) disable iff (rst_i)
      probe_cmd_i == probe_route_pkg::CMD_ANALOG |=>
         s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_ANALOG)
      else $error("analog command not applied");
   chk_analog_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.bus_enable[0] && s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_ANALOG
         |=> analog_on_o)
      else $error("analog mode not entered");
   chk_analog_pads: assert property (@(posedge clk_i) disable iff (rst_i)
      analog_on_o |-> pad_oe_o[1:0] == 2'b00)
      else $error("digital drive on dac pads");
   chk_zero_count: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.pad_map_count == 8'h00 ##1 1'b1 |-> pad_oe_o == $past(func_oe_i) || analog_on_o)
      else $error("map applied with zero count");
   chk_map_write: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_PAD_MAP |=>
         s_q.cfg.pad_probe_map[7:0] == $past(cfg_wdata_i))
      else $error("pad map byte not stored");
   chk_dac_two_src: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_DAC_TWO && probe_cmd_i == 2'b00 |=>
         s_q.cfg.dac_two_source == $past(cfg_wdata_i))
      else $error("dac two source not stored");
   chk_dac_one_src: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_DAC_ONE |=>
         s_q.cfg.dac_one_source == $past(cfg_wdata_i))
      else $error("dac one source not stored");

   // configuration bytes land at the edge that takes the write
   chk_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_BUS_ENABLE |=>
         s_q.cfg.bus_enable == $past(cfg_wdata_i))
      else $error("enable byte not stored");
   chk_count_write: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_MAP_COUNT |=>
         s_q.cfg.pad_map_count == $past(cfg_wdata_i))
      else $error("map count not stored");
   // a command in the same cycle overrides the written mode
   chk_mode_write: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_MODE
         && probe_cmd_i == probe_route_pkg::CMD_NONE |=>
         s_q.cfg.probe_bus_mode == $past(cfg_wdata_i))
      else $error("mode byte not stored");
   chk_mode_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      !cfg_we_i && probe_cmd_i == probe_route_pkg::CMD_NONE |=>
         $stable(s_q.cfg.probe_bus_mode))
      else $error("mode changed without write or command");
   chk_map_write_mid: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_PAD_MAP + 8'h01 |=>
         s_q.cfg.pad_probe_map[15:8] == $past(cfg_wdata_i))
      else $error("second pad map byte not stored");
   chk_map_write_top: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_PAD_MAP + 8'h03 |=>
         s_q.cfg.pad_probe_map[31:24] == $past(cfg_wdata_i))
      else $error("last pad map byte not stored");

   // read data is the byte addressed one cycle earlier
   chk_read_enable: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_addr_i == probe_route_pkg::ADDR_BUS_ENABLE |=>
         cfg_rdata_o == $past(s_q.cfg.bus_enable))
      else $error("enable byte read back wrong");
   chk_read_count: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_addr_i == probe_route_pkg::ADDR_MAP_COUNT |=>
         cfg_rdata_o == $past(s_q.cfg.pad_map_count))
      else $error("map count read back wrong");
   chk_read_map: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_addr_i == probe_route_pkg::ADDR_PAD_MAP |=>
         cfg_rdata_o == $past(s_q.cfg.pad_probe_map[7:0]))
      else $error("pad map read back wrong");
   chk_read_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_addr_i == probe_route_pkg::ADDR_MODE |=>
         cfg_rdata_o == $past(s_q.cfg.probe_bus_mode))
      else $error("mode byte read back wrong");
   chk_read_dac_one: assert property (@(posedge clk_i) disable iff (rst_i)
      cfg_addr_i == probe_route_pkg::ADDR_DAC_ONE |=>
         cfg_rdata_o == $past(s_q.cfg.dac_one_source))
      else $error("dac one source read back wrong");

   // each dac follows the data word its source byte picks, one cycle behind
   chk_dac_one_word: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.bus_enable[0] && s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_ANALOG
         && !s_q.cfg.dac_one_source[0] |=> dac_one_word_o == $past(dsp_word_one_i))
      else $error("dac one word not converted");
   chk_dac_two_word: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.bus_enable[0] && s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_ANALOG
         && s_q.cfg.dac_two_source[0] |=> dac_two_word_o == $past(dsp_word_two_i))
      else $error("dac two word not converted");
   chk_disabled_no_dac: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.cfg.bus_enable[0] |=> !analog_on_o)
      else $error("analog probing while disabled");
   chk_digital_no_analog: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_DIGITAL |=> !analog_on_o)
      else $error("analog probing in digital mode");

   // pads left out of the probe routing keep their normal function
   chk_func_val_pass: assert property (@(posedge clk_i) disable iff (rst_i)
      !s_q.cfg.bus_enable[0] ##1 1'b1 |-> pad_val_o == $past(func_val_i))
      else $error("pad values altered while disabled");
   chk_reserved_pad: assert property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.bus_enable[0] && s_q.cfg.probe_bus_mode == probe_route_pkg::MODE_DIGITAL
         && s_q.cfg.pad_map_count == 8'h01
         && s_q.cfg.pad_probe_map[7:4] > probe_route_pkg::PAD_LAST |=>
         pad_oe_o == $past(func_oe_i))
      else $error("reserved pad code routed");
   chk_analog_func_pads: assert property (@(posedge clk_i) disable iff (rst_i)
      analog_on_o |-> pad_oe_o[3:2] == $past(func_oe_i[3:2]))
      else $error("non dac pads altered in analog mode");

   // main scenarios
   cov_digital: cover property (@(posedge clk_i) disable iff (rst_i) |pad_oe_o && !analog_on_o
      && s_q.cfg.bus_enable[0]);
   cov_analog: cover property (@(posedge clk_i) disable iff (rst_i) analog_on_o);
   cov_clock_pad: cover property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.pad_probe_map[3:0] == probe_route_pkg::BIT_SEL_CLOCK && s_q.cfg.bus_enable[0]);
   cov_reserved_skip: cover property (@(posedge clk_i) disable iff (rst_i)
      s_q.cfg.pad_probe_map[7:4] > probe_route_pkg::PAD_LAST && s_q.cfg.bus_enable[0]);
   cov_mode_write: cover property (@(posedge clk_i) disable iff (rst_i)
      cfg_we_i && cfg_addr_i == probe_route_pkg::ADDR_MODE);
endmodule : debug_testbus_routing

//--- dv/cfg_host_model.sv
`timescale 1ns/1ps
module cfg_host_model (
   // clock
   input wire logic clk_i,
   // configuration port
   output logic [7:0] cfg_addr_o,
   output logic [7:0] cfg_wdata_o,
   output logic cfg_we_o,
   output logic [1:0] probe_cmd_o
);
   initial begin
      cfg_addr_o = 8'h00;
      cfg_wdata_o = 8'h00;
      cfg_we_o = 1'b0;
      probe_cmd_o = 2'h0;
   end
   // one strobe per byte; data is scrambled once the strobe drops
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_i);
      cfg_addr_o = a;
      cfg_wdata_o = d;
      cfg_we_o = 1'b1;
      @(negedge clk_i);
      cfg_we_o = 1'b0;
      cfg_wdata_o = ~d;
   endtask : wr
   // each probe type has its own command
   task automatic cmd(input probe_route_pkg::probe_cmd_t c);
      @(negedge clk_i);
      probe_cmd_o = c;
      @(negedge clk_i);
      probe_cmd_o = probe_route_pkg::CMD_NONE;
   endtask : cmd
   task automatic rd(input logic [7:0] a);
      @(negedge clk_i);
      cfg_addr_o = a;
      @(negedge clk_i);
   endtask : rd
endmodule : cfg_host_model

//--- dv/debug_testbus_routing_test.sv
`timescale 1ns/1ps
module debug_testbus_routing_test;
   logic clk_i, rst_i, cfg_we_i, clk13_i, analog_on_o;
   logic [1:0] probe_cmd_i;
   logic [3:0] func_val_i, func_oe_i, pad_val_o, pad_oe_o;
   logic [7:0] cfg_addr_i, cfg_wdata_i, cfg_rdata_o, probe_bus_i;
   logic [7:0] dsp_word_one_i, dsp_word_two_i, dac_one_word_o, dac_two_word_o;
   int errors = 0;
   int compares = 0;
   logic [7:0] addrs [10] = '{8'h17, 8'hF0, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7,
                                   8'hF8, 8'hF9, 8'h20};
   logic [7:0] maps [4] = '{8'h06, 8'h13, 8'h28, 8'h31};
   cfg_host_model host (.clk_i(clk_i), .cfg_addr_o(cfg_addr_i), .cfg_wdata_o(cfg_wdata_i),
      .cfg_we_o(cfg_we_i), .probe_cmd_o(probe_cmd_i));
   debug_testbus_routing uut (.clk_i(clk_i), .rst_i(rst_i), .cfg_addr_i(cfg_addr_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_we_i(cfg_we_i), .probe_cmd_i(probe_cmd_i),
      .cfg_rdata_o(cfg_rdata_o), .probe_bus_i(probe_bus_i), .clk13_i(clk13_i),
      .func_val_i(func_val_i), .func_oe_i(func_oe_i), .dsp_word_one_i(dsp_word_one_i),
      .dsp_word_two_i(dsp_word_two_i), .pad_val_o(pad_val_o), .pad_oe_o(pad_oe_o),
      .analog_on_o(analog_on_o), .dac_one_word_o(dac_one_word_o),
      .dac_two_word_o(dac_two_word_o));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic pads(input logic [3:0] v, input logic [3:0] o);
      repeat (3) @(negedge clk_i);
      chk({4'h0, pad_val_o}, {4'h0, v}, "pad value");
      chk({4'h0, pad_oe_o}, {4'h0, o}, "pad enable");
   endtask : pads
   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      host.rd(a);
      chk(cfg_rdata_o, e, "read data");
   endtask : rdchk
   task automatic conclude;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   // hang guard
   initial begin
      #40000;
      errors++;
      conclude();
   end
   initial begin
      rst_i = 1'b1;
      probe_bus_i = 8'h42;
      clk13_i = 1'b1;
      func_val_i = 4'h5;
      func_oe_i = 4'ha;
      dsp_word_one_i = 8'h3c;
      dsp_word_two_i = 8'hc3;
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      foreach (addrs[i]) rdchk(addrs[i], 8'h00);
      pads(4'h5, 4'ha);
      $display("test reset done");
      foreach (maps[i]) host.wr(8'hF4 + 8'(i), maps[i]);
      host.wr(8'hF3, 8'h04);
      host.cmd(probe_route_pkg::CMD_DIGITAL);
      pads(4'h5, 4'ha);
      foreach (maps[i]) rdchk(8'hF4 + 8'(i), maps[i]);
      rdchk(8'hF0, 8'h02);
      $display("test disabled done");
      host.wr(8'h17, 8'h01);
      pads(4'hd, 4'hf);
      probe_bus_i = 8'hbd;
      clk13_i = 1'b0;
      pads(4'h2, 4'hf);
      $display("test digital done");
      host.wr(8'hF3, 8'h02);
      pads(4'h6, 4'hb);
      host.wr(8'hF4, 8'h45);
      host.wr(8'hF3, 8'h01);
      pads(4'h5, 4'ha);
      $display("test count done");
      host.wr(8'hF8, 8'h00);
      host.wr(8'hF9, 8'h01);
      host.cmd(probe_route_pkg::CMD_ANALOG);
      repeat (3) @(negedge clk_i);
      chk({7'h0, analog_on_o}, 8'h01, "analog on");
      chk(dac_one_word_o, 8'h3c, "dac one");
      chk(dac_two_word_o, 8'hc3, "dac two");
      chk({6'h0, pad_oe_o[1:0]}, 8'h00, "dac pads");
      pads(4'h4, 4'h8);
      rdchk(8'hF0, 8'h01);
      host.cmd(probe_route_pkg::CMD_DIGITAL);
      repeat (3) @(negedge clk_i);
      chk({7'h0, analog_on_o}, 8'h00, "analog off");
      chk(dac_one_word_o, 8'h00, "dac idle");
      chk(dac_two_word_o, 8'h00, "dac two idle");
      $display("test analog done");
      host.wr(8'hF8, 8'h01);
      host.wr(8'hF9, 8'h00);
      host.wr(8'hF0, 8'h01);
      repeat (3) @(negedge clk_i);
      chk({7'h0, analog_on_o}, 8'h01, "mode write analog");
      chk(dac_one_word_o, 8'hc3, "dac one swapped");
      chk(dac_two_word_o, 8'h3c, "dac two swapped");
      host.wr(8'hF0, 8'h02);
      host.wr(8'hF3, 8'h04);
      pads(4'h3, 4'he);
      $display("test mode write done");
      host.wr(8'h17, 8'h00);
      pads(4'h5, 4'ha);
      $display("test disable done");
      conclude();
   end
endmodule : debug_testbus_routing_test
